// ===== hdl/sync_serial_module.sv
// Summary of operation
// - Select-pin sync only in mode 0100
// - Select low drives output; high floats it
// - Select high or disable clears bit counter
// - SPI master freezes in Sleep, resumes after
// - Slave shifts in any power mode
// - Wake: Sleep slave only, Idle any
// - Reset disables port, aborts transfer
// - Idle level and edge map SPI modes
// - Address register reloads baud in master
// - Mask qualifies slave address bits
// - Received byte moves to buffer, flags
// - Transmit write loads buffer and shifter
// - Status upper two writable, lower read-only
// - Status bit 7 controls slew limiting
// - Status bit 6 enables SMBus thresholds
// - Bit 5 data versus address, slave
// - Stop/start bits record last, cleared disable
// - Bit 2 read/write or transmit busy
// - OR of bit 2 and requests shows activity
// - Bit 1 asks address reload, ten-bit
// - Bit 0 shows buffer full
// - Mode field selects master or slave variants
// - Enable hands pins to the port
`timescale 1ns/10ps
`default_nettype none
`include "sync_serial_map.svh"

module sync_serial_module (
  input wire logic clk,             // System clock
  input wire logic nrst,            // Async reset, active low
  input wire logic psel,            // APB select
  input wire logic penable,         // APB enable
  input wire logic pwrite,          // APB direction
  input wire logic [7:0] paddr,     // APB byte address
  input wire logic [31:0] pwdata,   // APB write data
  output logic [31:0] prdata,       // APB read data
  output logic pready,              // APB ready
  output logic pslverr,             // APB error on unmapped address
  input wire logic sleepMode,       // Device in Sleep
  input wire logic idleMode,        // Device in Idle
  input wire logic timerTick,       // Timer output pulse
  input wire logic sclkIn,          // Serial clock pin in
  output logic sclkOut,             // Serial clock pin out
  output logic sclkOe,              // Serial clock drive enable
  input wire logic sdiIn,           // Serial data in
  output logic sdoOut,              // Serial data out
  output logic sdoOe,               // Serial data drive enable
  input wire logic ssN,             // Slave select, active low
  input wire logic sclIn,           // I2C clock pin in
  output logic sclOut,              // I2C clock pin out
  output logic sclOe,               // I2C clock pull-low enable
  input wire logic sdaIn,           // I2C data pin in
  output logic sdaOut,              // I2C data pin out
  output logic sdaOe,               // I2C data pull-low enable
  output logic portFlag,            // Port interrupt flag
  output logic wakeRequest,         // Wake request to power control
  output logic masterActive,        // I2C master activity
  output logic slewLimitEn,         // Slew-rate limiting on pins
  output logic smbusInputEn         // SMBus input thresholds on
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decoding

  function automatic logic isSpiMaster(input logic [3:0] m);
    return m <= `MODE_SPI_TIMER;
  endfunction

  function automatic logic isSpiSlave(input logic [3:0] m);
    return (m == `MODE_SPI_SLAVE_SEL) || (m == `MODE_SPI_SLAVE_FREE);
  endfunction

  function automatic logic isI2cSlave(input logic [3:0] m);
    return (m == `MODE_I2C_SLAVE7) || (m == `MODE_I2C_SLAVE10) ||
           (m == `MODE_I2C_SLAVE7_SP) || (m == `MODE_I2C_SLAVE10_SP);
  endfunction

  function automatic logic isI2cMaster(input logic [3:0] m);
    return (m == `MODE_I2C_MASTER) || (m == `MODE_I2C_FW_MASTER);
  endfunction

  function automatic logic isTenBit(input logic [3:0] m);
    return (m == `MODE_I2C_SLAVE10) || (m == `MODE_I2C_SLAVE10_SP);
  endfunction

  function automatic logic addrHit(input logic [7:0] a);
    return (a == `OFF_SERIAL_BUFFER) || (a == `OFF_CONTROL_ONE) || (a == `OFF_STATUS) ||
           (a == `OFF_ADDR_RELOAD) || (a == `OFF_ADDR_MASK) || (a == `OFF_CONTROL_TWO) ||
           (a == `OFF_PORT_FLAG);
  endfunction

  // A finished byte goes to the buffer unless the last one is unread or overflow is set
  function automatic sync_serial_pkg::state_t storeByte(input sync_serial_pkg::state_t t,
                                                         input logic [7:0] b);
    sync_serial_pkg::state_t r;
    r = t;
    if (t.bufFull || t.ctrlOne[`CTL1_OVERFLOW]) begin
      r.ctrlOne[`CTL1_OVERFLOW] = 1'b1;
    end else begin
      r.buffer = b;
      r.bufFull = 1'b1;
    end
    r.portFlag = 1'b1;
    return r;
  endfunction

  sync_serial_pkg::state_t s, n;

  logic [3:0] mode;
  logic en, clock_idle_level, cpha, spiM, spiS, ssCtl, i2cS, i2cM, spiActive;
  logic [5:0] halfPer;
  logic halfDone, mTick, lead, trail, sclRise, sclFall, startCond, stopCond;
  logic brgTick, collision, setup, access, wr, rd, rwShown, addrMatch;
  logic [7:0] spiShifted, statusVal;

  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls and pin events

  assign mode = s.ctrlOne[3:0];
  assign en = s.ctrlOne[`CTL1_ENABLE];
  assign clock_idle_level = s.ctrlOne[`CTL1_IDLE_LEVEL];
  assign cpha = ~s.statusCtl[0];
  assign spiM = isSpiMaster(mode);
  assign spiS = isSpiSlave(mode);
  assign ssCtl = mode == `MODE_SPI_SLAVE_SEL;
  assign i2cS = isI2cSlave(mode);
  assign i2cM = isI2cMaster(mode);
  assign spiActive = en && spiS && (!ssCtl || !ssN);

  // Master bit clock; the divider does not run in Sleep so the transfer freezes
  assign halfPer = (mode == `MODE_SPI_DIV4) ? `HALF_DIV4 :
                   (mode == `MODE_SPI_DIV16) ? `HALF_DIV16 : `HALF_DIV64;
  assign halfDone = (mode == `MODE_SPI_TIMER) ? timerTick : (s.divCnt == halfPer - 6'h01);
  assign mTick = en && spiM && s.busy && !sleepMode && halfDone;

  // Slave edges are seen whatever the power mode, since the pin drives them
  assign lead = spiM ? (mTick && s.sclkOutQ == clock_idle_level) :
                (spiActive && sclkIn != s.sclkPrev && s.sclkPrev == clock_idle_level);
  assign trail = spiM ? (mTick && s.sclkOutQ != clock_idle_level) :
                 (spiActive && sclkIn != s.sclkPrev && s.sclkPrev != clock_idle_level);
  assign spiShifted = {s.shifter[6:0], cpha ? sdiIn : s.sampleBit};

  assign sclRise = sclIn && !s.sclPrev;
  assign sclFall = !sclIn && s.sclPrev;
  assign startCond = sclIn && s.sclPrev && s.sdaPrev && !sdaIn;
  assign stopCond = sclIn && s.sclPrev && !s.sdaPrev && sdaIn;
  assign addrMatch = ((s.shifter[7:1] ^ s.addrReload[7:1]) & s.addrMask[7:1]) == 7'h00;
  assign brgTick = en && i2cM && s.brgCnt == 8'h00;

  assign collision = (spiM && s.busy) || (spiS && s.bitCnt != 4'h0) || (i2cM && s.busy);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;

  // Bit 2 means read/write as slave, transmit busy as master
  assign rwShown = i2cM ? s.busy : s.rwBit;
  assign statusVal = {s.statusCtl, i2cS && s.dataAddr, s.stopSeen, s.startSeen, rwShown,
                      s.updAddr, s.bufFull};

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    n = s;
    n.sclkPrev = sclkIn;
    n.sclPrev = sclIn;
    n.sdaPrev = sdaIn;

    // Read data is captured in setup so that the bus sees a flop
    if (setup) begin
      if (paddr == `OFF_SERIAL_BUFFER) begin
        n.prdata = {24'h000000, s.buffer};
      end else if (paddr == `OFF_CONTROL_ONE) begin
        n.prdata = {24'h000000, s.ctrlOne};
      end else if (paddr == `OFF_STATUS) begin
        n.prdata = {24'h000000, statusVal};
      end else if (paddr == `OFF_ADDR_RELOAD) begin
        n.prdata = {24'h000000, s.addrReload};
      end else if (paddr == `OFF_ADDR_MASK) begin
        n.prdata = {24'h000000, s.addrMask};
      end else if (paddr == `OFF_CONTROL_TWO) begin
        n.prdata = {27'h0, s.ctrlTwo};
      end else if (paddr == `OFF_PORT_FLAG) begin
        n.prdata = {30'h0, s.flagEn, s.portFlag};
      end else begin
        n.prdata = 32'h00000000;
      end
    end

    // Software writes come first so that hardware sets below win
    if (wr) begin
      if (paddr == `OFF_SERIAL_BUFFER) begin
        if (collision) begin
          n.ctrlOne[`CTL1_WRITE_COLL] = 1'b1;
        end else begin
          n.buffer = pwdata[7:0];
          n.shifter = pwdata[7:0];
          if (i2cS || i2cM) begin
            n.bufFull = 1'b1;
          end
          if (spiM || i2cM) begin
            n.busy = 1'b1;
            n.bitCnt = 4'h0;
            n.divCnt = 6'h00;
          end
        end
      end else if (paddr == `OFF_CONTROL_ONE) begin
        n.ctrlOne = pwdata[7:0];
      end else if (paddr == `OFF_STATUS) begin
        n.statusCtl = pwdata[7:6];
      end else if (paddr == `OFF_ADDR_RELOAD) begin
        n.addrReload = pwdata[7:0];
        n.updAddr = 1'b0;
      end else if (paddr == `OFF_ADDR_MASK) begin
        n.addrMask = pwdata[7:0];
      end else if (paddr == `OFF_CONTROL_TWO) begin
        n.ctrlTwo = pwdata[4:0];
      end else if (paddr == `OFF_PORT_FLAG) begin
        if (pwdata[`FLAG_PENDING]) begin
          n.portFlag = 1'b0;
        end
        n.flagEn = pwdata[`FLAG_ENABLE];
      end
    end
    if (rd && paddr == `OFF_SERIAL_BUFFER) begin
      n.bufFull = 1'b0;
    end

    // SPI master divider and clock toggle
    if (en && spiM && s.busy && !sleepMode && mode != `MODE_SPI_TIMER) begin
      n.divCnt = halfDone ? 6'h00 : s.divCnt + 6'h01;
    end
    if (mTick) begin
      n.sclkOutQ = ~s.sclkOutQ;
    end

    // Shared SPI shifter: shift on the trailing edge; sample on the leading edge when cpha is low, on the trailing when high
    if (lead) begin
      if (cpha) begin
        n.outBit = s.shifter[7];
      end else begin
        n.sampleBit = sdiIn;
      end
    end
    if (trail) begin
      n.shifter = spiShifted;
      n.bitCnt = s.bitCnt + 4'h1;
      if (s.bitCnt == `LAST_BIT) begin
        n = storeByte(n, spiShifted);
        n.bitCnt = 4'h0;
        n.busy = 1'b0;
      end
    end
    if (en && ssCtl && ssN) begin
      n.bitCnt = 4'h0;
    end

    // I2C slave receive path
    if (en && i2cS) begin
      if (startCond) begin
        n.startSeen = 1'b1;
        n.stopSeen = 1'b0;
        n.bitCnt = 4'h0;
        n.firstByte = 1'b1;
        n.matched = 1'b0;
        n.rwBit = 1'b0;
      end else if (stopCond) begin
        n.stopSeen = 1'b1;
        n.startSeen = 1'b0;
        n.matched = 1'b0;
        n.rwBit = 1'b0;
        n.ackDrive = 1'b0;
      end else if (sclRise && s.bitCnt < `BYTE_BITS) begin
        n.shifter = {s.shifter[6:0], sdaIn};
        n.bitCnt = s.bitCnt + 4'h1;
      end else if (sclFall && s.bitCnt == `BYTE_BITS) begin
        n.bitCnt = `ACK_SLOT;
        if (s.firstByte) begin
          n.firstByte = 1'b0;
          if (addrMatch) begin
            n = storeByte(n, s.shifter);
            n.matched = 1'b1;
            n.dataAddr = 1'b0;
            n.rwBit = s.shifter[0];
            n.updAddr = isTenBit(mode);
            n.ackDrive = !s.bufFull && !s.ctrlOne[`CTL1_OVERFLOW];
          end
        end else if (s.matched) begin
          n = storeByte(n, s.shifter);
          n.dataAddr = 1'b1;
          n.ackDrive = !s.bufFull && !s.ctrlOne[`CTL1_OVERFLOW];
        end
      end else if (sclFall && s.bitCnt == `ACK_SLOT) begin
        n.ackDrive = 1'b0;
        n.bitCnt = 4'h0;
      end
    end

    // I2C master: the address register is the baud reload
    if (en && i2cM) begin
      n.brgCnt = brgTick ? s.addrReload : s.brgCnt - 8'h01;
      if (brgTick) begin
        n.ctrlTwo[`CTL2_START] = 1'b0;
        n.ctrlTwo[`CTL2_RESTART] = 1'b0;
        n.ctrlTwo[`CTL2_STOP] = 1'b0;
        n.ctrlTwo[`CTL2_ACK_SEQ] = 1'b0;
        if (s.busy) begin
          n.shifter = {s.shifter[6:0], 1'b0};
          n.bitCnt = s.bitCnt + 4'h1;
          if (s.bitCnt == `LAST_BIT) begin
            n.busy = 1'b0;
            n.bufFull = 1'b0;
            n.bitCnt = 4'h0;
          end
        end
      end
    end

    // Disabling the port aborts everything and clears bus history
    if (!n.ctrlOne[`CTL1_ENABLE]) begin
      n.bitCnt = 4'h0;
      n.busy = 1'b0;
      n.startSeen = 1'b0;
      n.stopSeen = 1'b0;
      n.ackDrive = 1'b0;
      n.matched = 1'b0;
      n.divCnt = 6'h00;
    end
    if (!n.busy) begin
      n.sclkOutQ = n.ctrlOne[`CTL1_IDLE_LEVEL];
    end
  end

  // State register; reset leaves the port disabled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.ctrlOne <= `RST_CONTROL_ONE;
      s.statusCtl <= `RST_STATUS_CTL;
      s.addrMask <= `RST_ADDR_MASK;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = access && !addrHit(paddr);
  // Pins belong to the port only while it is enabled
  assign sclkOut = s.sclkOutQ;
  assign sclkOe = en && spiM;
  assign sdoOut = cpha ? s.outBit : s.shifter[7];
  // The release follows the select pin with no clock, even mid-byte
  assign sdoOe = en && (spiM || (spiS && (!ssCtl || !ssN)));
  assign sclOut = 1'b0;
  assign sclOe = 1'b0;
  assign sdaOut = 1'b0;
  assign sdaOe = en && i2cS && s.ackDrive;
  assign portFlag = s.portFlag;
  assign wakeRequest = s.portFlag && s.flagEn && ((sleepMode && (spiS || i2cS)) || idleMode);
  assign masterActive = en && i2cM && (rwShown || (s.ctrlTwo != 5'h00));
  assign slewLimitEn = en && (i2cS || i2cM) && !s.statusCtl[1];
  assign smbusInputEn = en && (i2cS || i2cM) && s.statusCtl[0];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_sdo_release: assert property (en && ssCtl && ssN |-> !sdoOe)
    else $error("data output driven while select high");
  a_ss_counter: assert property (en && ssCtl && ssN |=> s.bitCnt == 4'h0)
    else $error("bit counter not cleared by select");
  a_disable_clear: assert property ($fell(en) |-> s.bitCnt == 4'h0 && !s.startSeen && !s.stopSeen)
    else $error("disable did not clear state");
  a_sleep_freeze: assert property (en && spiM && s.busy && sleepMode ##1 en |-> $stable(s.sclkOutQ))
    else $error("master clock moved in sleep");
  a_byte_flag: assert property (trail && s.bitCnt == 4'h7 |=> s.portFlag && s.bitCnt == 4'h0)
    else $error("byte end did not raise flag");
  a_sleep_wake: assert property (sleepMode && !idleMode && !spiS && !i2cS |-> !wakeRequest)
    else $error("sleep wake outside slave mode");
  a_sample_edge: assert property (lead && !cpha |=> s.sampleBit == $past(sdiIn))
    else $error("sample not taken on leading edge");
  a_brg_reload: assert property (brgTick ##1 en && i2cM |-> s.brgCnt == $past(s.addrReload))
    else $error("baud counter not reloaded");
  a_rx_load: assert property (en && i2cS && sclFall && s.bitCnt == 4'h8 && !s.firstByte && s.matched &&
                              !s.bufFull && !s.ctrlOne[6] && !startCond && !stopCond
                              |=> s.bufFull && s.portFlag && s.buffer == $past(s.shifter))
    else $error("received byte not moved to buffer");
  a_tx_load: assert property (wr && paddr == 8'h00 && i2cM && !collision |=> s.buffer == s.shifter)
    else $error("transmit write not mirrored");
  a_master_act: assert property (en && i2cM && s.ctrlTwo != 5'h00 |-> masterActive)
    else $error("master activity not shown");

  c_spi_byte: cover property (trail && s.bitCnt == 4'h7 && spiS);
  c_i2c_match: cover property (en && i2cS && sclFall && s.bitCnt == 4'h8 && s.firstByte && addrMatch);
  c_sleep_wake: cover property (sleepMode && wakeRequest);
  c_master_done: cover property (en && spiM && s.busy ##1 !s.busy);

endmodule

`default_nettype wire

// ===== hdl/sync_serial_map.svh
`ifndef SYNC_SERIAL_MAP_SVH
`define SYNC_SERIAL_MAP_SVH
// Register byte offsets on the APB
`define OFF_SERIAL_BUFFER 8'h00
`define OFF_CONTROL_ONE 8'h04
`define OFF_STATUS 8'h08
`define OFF_ADDR_RELOAD 8'h0C
`define OFF_ADDR_MASK 8'h10
`define OFF_CONTROL_TWO 8'h14
`define OFF_PORT_FLAG 8'h18
// Control-one field positions
`define CTL1_WRITE_COLL 7
`define CTL1_OVERFLOW 6
`define CTL1_ENABLE 5
`define CTL1_IDLE_LEVEL 4
// Flag register field positions
`define FLAG_PENDING 0
`define FLAG_ENABLE 1
// Control-two field positions
`define CTL2_START 0
`define CTL2_RESTART 1
`define CTL2_STOP 2
`define CTL2_RECEIVE 3
`define CTL2_ACK_SEQ 4
// Reset values
`define RST_CONTROL_ONE 8'h00
`define RST_STATUS_CTL 2'h0
`define RST_ADDR_MASK 8'hFF
// Port mode codes
`define MODE_SPI_DIV4 4'h0
`define MODE_SPI_DIV16 4'h1
`define MODE_SPI_DIV64 4'h2
`define MODE_SPI_TIMER 4'h3
`define MODE_SPI_SLAVE_SEL 4'h4
`define MODE_SPI_SLAVE_FREE 4'h5
`define MODE_I2C_SLAVE7 4'h6
`define MODE_I2C_SLAVE10 4'h7
`define MODE_I2C_MASTER 4'h8
`define MODE_I2C_FW_MASTER 4'hB
`define MODE_I2C_SLAVE7_SP 4'hE
`define MODE_I2C_SLAVE10_SP 4'hF
// Serial clock half periods in system clocks, and bit counts
`define HALF_DIV4 6'h02
`define HALF_DIV16 6'h08
`define HALF_DIV64 6'h20
`define LAST_BIT 4'h7
`define BYTE_BITS 4'h8
`define ACK_SLOT 4'h9
`endif

// ===== hdl/sync_serial_pkg.sv
package sync_serial_pkg;
  // Whole state of the port, registered in one place
  typedef struct packed {
    logic [7:0] ctrlOne;
    logic [1:0] statusCtl;
    logic dataAddr;
    logic stopSeen;
    logic startSeen;
    logic rwBit;
    logic updAddr;
    logic bufFull;
    logic [7:0] buffer;
    logic [7:0] shifter;
    logic [7:0] addrReload;
    logic [7:0] addrMask;
    logic [4:0] ctrlTwo;
    logic portFlag;
    logic flagEn;
    logic outBit;
    logic sampleBit;
    logic [3:0] bitCnt;
    logic busy;
    logic sclkPrev;
    logic sclkOutQ;
    logic [5:0] divCnt;
    logic sclPrev;
    logic sdaPrev;
    logic firstByte;
    logic matched;
    logic ackDrive;
    logic [7:0] brgCnt;
    logic [31:0] prdata;
  } state_t;
endpackage

// ===== sim/spi_master_model.sv
`timescale 1ns/10ps
`default_nettype none

module spi_master_model (
  input wire logic clk,  // Pacing clock
  input wire logic miso, // Data from the port
  output logic sclk,     // Serial clock, idle low
  output logic mosi,     // Data to the port
  output logic selN      // Select, active low
);
  // Half period in system clocks; the port needs at least two per level
  int half = 2;
  logic [7:0] got = 8'h00;

  ////////////////////////////////////////
  // Lines start idle; the clock stands still between frames
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    selN = 1'b1;
  end

  // Pacing helper
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Select or deselect; a released data line never keeps its last value
  task automatic select(input logic on);
    @(posedge clk);
    selN <= !on;
    if (!on) begin
      mosi <= !mosi;
    end
  endtask

  // Shift nb bits MSB first; the leading edge is the sampling edge
  task automatic shift(input logic [7:0] b, input int nb);
    for (int i = 7; i > 7 - nb; i--) begin
      @(posedge clk);
      mosi <= b[i];
      wt(half);
      sclk <= 1'b1;
      got <= {got[6:0], miso};
      wt(half);
      sclk <= 1'b0;
    end
    wt(half);
    mosi <= !mosi;
  endtask
endmodule

`default_nettype wire

// ===== sim/sync_serial_module_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "sync_serial_map.svh"

module sync_serial_module_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sleepMode = 1'b0;
  logic idleMode = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, sclk, mosi, selN, sclkOut, sclkOe, sdoOut, sdoOe;
  logic portFlag, wakeRequest, masterActive, slewLimitEn, smbusInputEn;
  int errCount = 0;
  int checkCount = 0;
  int seed = 32'h7762;
  logic [31:0] rd;
  logic er;
  logic [7:0] b;
  logic [7:0] pb;
  // I2C lines are open drain: the port pulls data low against the pull-up
  logic sclIn = 1'b1;
  logic sdaDrv = 1'b1;
  logic sdaOe;
  wire logic sdaLine;
  assign sdaLine = sdaDrv && !sdaOe;

  ////////////////////////////////////////
  // Clock and units under test; I2C pins sit at their pull-up level
  always #2 clk = ~clk;

  sync_serial_module dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleepMode(sleepMode), .idleMode(idleMode), .timerTick(1'b0),
    .sclkIn(sclk), .sclkOut(sclkOut), .sclkOe(sclkOe), .sdiIn(mosi), .sdoOut(sdoOut),
    .sdoOe(sdoOe), .ssN(selN), .sclIn(sclIn), .sclOut(), .sclOe(), .sdaIn(sdaLine),
    .sdaOut(), .sdaOe(sdaOe), .portFlag(portFlag), .wakeRequest(wakeRequest),
    .masterActive(masterActive), .slewLimitEn(slewLimitEn), .smbusInputEn(smbusInputEn));

  spi_master_model pm (.clk(clk), .miso(sdoOut), .sclk(sclk), .mosi(mosi), .selN(selN));

  ////////////////////////////////////////
  // Verdict, comparison and expectation helpers
  task automatic printVerdict();
    $display("checks %0d errors %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Status in SPI with edge select set: only the full bit moves
  function automatic logic [31:0] statusExp(input logic full);
    return 32'h40 | 32'(full);
  endfunction

  // I2C status with both upper controls set; f is bits 5 down to 0
  function automatic logic [31:0] i2cStat(input logic [5:0] f);
    return {24'h000000, 2'b11, f};
  endfunction

  // One I2C clock; data changes only while the clock is low, levels stand two clocks
  task automatic i2cBit(input logic v);
    @(posedge clk);
    sdaDrv <= v;
    repeat (2) @(posedge clk);
    sclIn <= 1'b1;
    repeat (2) @(posedge clk);
    sclIn <= 1'b0;
  endtask

  task automatic i2cByte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      i2cBit(v[i]);
    end
  endtask

  // Start: data falls under a high clock
  task automatic i2cStart();
    @(posedge clk);
    sdaDrv <= 1'b0;
    repeat (2) @(posedge clk);
    sclIn <= 1'b0;
  endtask

  // Stop: data rises under a high clock
  task automatic i2cStop();
    @(posedge clk);
    sdaDrv <= 1'b0;
    repeat (2) @(posedge clk);
    sclIn <= 1'b1;
    repeat (2) @(posedge clk);
    sdaDrv <= 1'b1;
  endtask

  // One APB transfer, an idle cycle before it so the strobes never double up
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errCount++;
      printVerdict();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Bounded wait for the flag, sampled after the edge has settled
  task automatic waitFlag();
    int n;
    n = 0;
    while (portFlag !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(32'(portFlag), 32'h1);
    if (portFlag !== 1'b1) printVerdict();
  endtask

  ////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rdchk(`OFF_CONTROL_ONE, 32'h0);
    rdchk(`OFF_STATUS, 32'h0);
    rdchk(`OFF_ADDR_MASK, 32'hFF);
    xfer(1'b0, 8'h1C, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    wr(`OFF_STATUS, 32'hFF);
    rdchk(`OFF_STATUS, 32'hC0);
    // Slew and SMBus controls over all four settings in I2C slave mode
    wr(`OFF_CONTROL_ONE, 32'h26);
    for (int i = 0; i < 4; i++) begin
      wr(`OFF_STATUS, 32'(i << 6));
      #1 chk(32'({slewLimitEn, smbusInputEn}), 32'({~i[1], i[0]}));
    end
    // I2C slave: masked address match, a random data byte, then a stop
    wr(`OFF_ADDR_RELOAD, 32'hA4);
    wr(`OFF_ADDR_MASK, 32'hF9);
    i2cStart();
    i2cByte(8'hA3);
    @(posedge clk);
    #1 chk(32'(sdaOe), 32'h1);
    i2cBit(1'b1);
    rdchk(`OFF_STATUS, i2cStat(6'h0D));
    rdchk(`OFF_SERIAL_BUFFER, 32'hA3);
    b = 8'($random(seed));
    i2cByte(b);
    i2cBit(1'b1);
    rdchk(`OFF_STATUS, i2cStat(6'h2D));
    rdchk(`OFF_SERIAL_BUFFER, 32'(b));
    i2cStop();
    rdchk(`OFF_STATUS, i2cStat(6'h30));
    wr(`OFF_PORT_FLAG, 32'h1);
    wr(`OFF_CONTROL_ONE, 32'h28);
    wr(`OFF_CONTROL_TWO, 32'h08);
    #1 chk(32'(masterActive), 32'h1);
    wr(`OFF_CONTROL_TWO, 32'h00);
    #1 chk(32'(masterActive), 32'h0);
    // Master transmit write fills buffer and shifter; disabling clears history
    wr(`OFF_SERIAL_BUFFER, 32'h96);
    #1 chk(32'(masterActive), 32'h1);
    rdchk(`OFF_STATUS, i2cStat(6'h15));
    rdchk(`OFF_SERIAL_BUFFER, 32'h96);
    wr(`OFF_CONTROL_ONE, 32'h00);
    rdchk(`OFF_STATUS, 32'hC0);
    // Select-controlled slave: a partial byte is cut short before each full one
    wr(`OFF_STATUS, 32'h40);
    wr(`OFF_CONTROL_ONE, 32'h24);
    wr(`OFF_PORT_FLAG, 32'h2);
    for (int k = 0; k < 4; k++) begin
      b = (k == 0) ? 8'hFF : 8'($random(seed));
      pm.half = 2 + k;
      pm.select(1'b1);
      pm.wt(3);
      chk(32'(sdoOe), 32'h1);
      pm.shift(8'h00, 3);
      pm.select(1'b0);
      #1 chk(32'(sdoOe), 32'h0);
      sleepMode <= k[0];
      pm.select(1'b1);
      pm.shift(b, 8);
      // The port sends what the cut frame left: last byte moved up by three
      if (k > 0) chk(32'(pm.got), 32'({pb[4:0], 3'b000}));
      pb = b;
      pm.select(1'b0);
      waitFlag();
      chk(32'(wakeRequest), 32'(k[0]));
      sleepMode <= 1'b0;
      rdchk(`OFF_STATUS, statusExp(1'b1));
      rdchk(`OFF_SERIAL_BUFFER, 32'(b));
      rdchk(`OFF_STATUS, statusExp(1'b0));
      wr(`OFF_PORT_FLAG, 32'h3);
    end
    // Master: idle level, then a transfer frozen by Sleep and resumed
    wr(`OFF_CONTROL_ONE, 32'h30);
    #1 chk(32'({sclkOe, sclkOut}), 32'h3);
    wr(`OFF_CONTROL_ONE, 32'h20);
    wr(`OFF_SERIAL_BUFFER, $random(seed) & 32'hFF);
    repeat (6) @(posedge clk);
    sleepMode <= 1'b1;
    repeat (2) @(posedge clk);
    #1 rd[0] = sclkOut;
    repeat (20) @(posedge clk);
    #1 chk(32'({portFlag, sclkOut}), 32'({1'b0, rd[0]}));
    sleepMode <= 1'b0;
    waitFlag();
    sleepMode <= 1'b1;
    #1 chk(32'(wakeRequest), 32'h0);
    idleMode <= 1'b1;
    #1 chk(32'(wakeRequest), 32'h1);
    // Reset in mid-transfer
    sleepMode <= 1'b0;
    idleMode <= 1'b0;
    wr(`OFF_SERIAL_BUFFER, 32'h5A);
    repeat (4) @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1 chk(32'({sclkOe, portFlag}), 32'h0);
    rdchk(`OFF_CONTROL_ONE, 32'h0);
    printVerdict();
  end
endmodule

`default_nettype wire
